// file: spi_master_cfg.svh
`ifndef SPI_MASTER_CFG_SVH
`define SPI_MASTER_CFG_SVH

// controller modes and pin configurations
`define MODE_OFF        3'h0
`define MODE_SPI        3'h2
`define PINS_TWO_WIRE   2'h0
`define PINS_THREE_MST  2'h1
`define PINS_FOUR_SLV   2'h2

// serial word and fifo geometry
`define WORD_BITS       8
`define LAST_HALF_EDGE  4'hf
`define FIFO_DEPTH      4

// clock rates in mhz: reference feeding the divider, and sys_clk
`define REF_MHZ         24
`define SYS_MHZ         10

// filler bytes
`define BUSY_TOKEN      8'hff
`define POL_GLITCH_BYTE 8'hfe

// interrupt flag positions
`define IRQ_RXVAL       0
`define IRQ_TXFREE      1
`define IRQ_TXIDLE      2
`define IRQ_RXOVF       3
`define IRQ_TXUND       4
`define IRQ_RXULDA      9
`define IRQ_RXULDB      10
`define IRQ_TXULDA      11
`define IRQ_TXULDB      12
`define IRQ_WIDTH       16

`endif

// file: spi_pkg.sv
package spi_pkg;
    typedef enum logic [0:0] {
        XFER_IDLE,
        XFER_SHIFT
    } xfer_state_e;

    typedef struct packed {
        logic [2:0] controller_mode_select;
        logic       master_select_bit;
        logic       clock_polarity;
        logic       clock_phase;
        logic       bit_order;
        logic       repeat_select_bit;
        logic       auto_tx_enable;
        logic [1:0] pin_config;
        logic [3:0] rate_exponent;
        logic [3:0] rate_linear;
    } spi_cfg_s;

    typedef struct packed {
        logic tx_idle_flag;
        logic tx_free_flag;
        logic rx_valid_flag;
        logic rx_overrun_flag;
    } spi_status_s;
endpackage : spi_pkg

// file: spi_master_with_fifos.sv
// Contract
// - master logic runs only with master select set, pin_config at three-wire master, and controller in spi mode.
// - serial clock is 24 mhz over 2*(rate_linear+1)*2^rate_exponent, capped at 5 mhz (one tick per sys_clk).
// - rate exponent and rate linear are separate four-bit values, 0 to 15.
// - polarity and phase shape the frame; bit_order picks msb or lsb first.
// - polarity fall without mode reset sends one extra 0xfe byte first.
// - transmit bits leave on mosi, received bits are sampled from miso.
// - transmit and receive each have a four-byte fifo for software or dma.
// - a byte written into an empty transmit fifo clears tx_idle_flag.
// - tx_free_flag clears on full fifo, sets after a byte shifts out.
// - tx_idle_flag sets once the fifo is empty and the shifter is done.
// - received bytes enter the receive fifo; rx_valid_flag shows unread data.
// - bytes arriving at a full receive fifo are dropped, overrun flagged.
// - dma overrun error appears only after the receive fifo drains.
// - dma error clears on channel reset or reloading an unloaded buffer.
// - each received byte pairs with one transmitted byte.
// - auto transmit resends last byte or 0xff per repeat_select_bit.
// - every automatic byte sets tx_underrun_irq.
// - auto transmit off stops reception; receive fifo keeps its bytes.
// - receive dma completion does not imply an empty receive fifo.
// - interrupts on flag rises, dma active falls, overrun, underrun; two masks.
// - spi operation is selected by controller_mode_select equal to 2.
// - every transfer is exactly eight bits.
`timescale 1ns/1ps
`include "spi_master_cfg.svh"

module byte_fifo #(
    parameter int WIDTH = `WORD_BITS,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr, rd_ptr;
    logic [PW:0]      count;
    logic             push, pop;

    if (WIDTH < 1 || DEPTH < 2) begin : g_bad_geometry
        $error("byte_fifo: bad width or depth");
    end

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : byte_fifo

module spi_master_with_fifos #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  spi_pkg::spi_cfg_s            spi_config_reg,
    output spi_pkg::spi_status_s         spi_status_reg,
    input  wire logic                    rx_overrun_clear,
    input  wire logic                    tx_valid,
    output logic                         tx_ready,
    input  wire logic [7:0]              tx_data,
    output logic                         rx_valid,
    input  wire logic                    rx_ready,
    output logic [7:0]                   rx_data,
    output logic                         master_serial_clock,
    output logic                         mosi,
    input  wire logic                    miso,
    input  wire logic [1:0]              tx_dma_buffer_active,
    input  wire logic [1:0]              rx_dma_buffer_active,
    input  wire logic                    rx_dma_load,
    input  wire logic [1:0]              dma_channel_reset,
    output logic                         rx_dma_error,
    output logic [`IRQ_WIDTH-1:0]        irq_flag_reg,
    input  wire logic [`IRQ_WIDTH-1:0]   irq_flag_clear,
    input  wire logic [`IRQ_WIDTH-1:0]   irq_enable_reg,
    input  wire logic                    irq_global_enable,
    output logic                         irq
);
    import spi_pkg::*;
    localparam logic [23:0] STEP = 24'(`REF_MHZ);
    if (DEPTH < 2) begin : g_bad_depth
        $error("spi_master_with_fifos: depth below 2");
    end

    xfer_state_e           state;
    spi_status_s           status_d;
    logic                  active, start, start_auto, from_fifo, tick, change_edge, byte_done;
    logic                  tx_has, tx_pop, rx_push, rx_in_ready;
    logic                  pending_fe, pol_d, rx_err_pending, rx_unloaded;
    logic [1:0]            tx_act_d, rx_act_d;
    logic [3:0]            half_cnt;
    logic [7:0]            tx_head, load_byte, last_tx, tx_sr, rx_sr, next_rx_sr;
    logic [23:0]           acc, next_acc, thresh;
    logic [`IRQ_WIDTH-1:0] events;

    // master enable decode
    assign active = (spi_config_reg.controller_mode_select == `MODE_SPI)
                 && spi_config_reg.master_select_bit
                 && (spi_config_reg.pin_config == `PINS_THREE_MST);

    byte_fifo #(.WIDTH(`WORD_BITS), .DEPTH(DEPTH)) u_tx_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (tx_has),
        .out_ready (tx_pop),
        .out_data  (tx_head)
    );

    byte_fifo #(.WIDTH(`WORD_BITS), .DEPTH(DEPTH)) u_rx_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (next_rx_sr),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // start of a byte: pending 0xfe, else queued data, else automatic filler
    assign start      = (state == XFER_IDLE) && active
                     && (tx_has || spi_config_reg.auto_tx_enable);
    assign start_auto = start && !tx_has && !pending_fe;
    always_comb begin
        if (pending_fe) begin
            load_byte = `POL_GLITCH_BYTE;
        end else if (tx_has) begin
            load_byte = tx_head;
        end else if (spi_config_reg.repeat_select_bit) begin
            load_byte = last_tx;
        end else begin
            load_byte = `BUSY_TOKEN;
        end
    end

    // divider: half period is (lin+1)<<exp reference cycles
    assign thresh   = ((24'(spi_config_reg.rate_linear) + 24'h1)
                       << spi_config_reg.rate_exponent) * 24'(`SYS_MHZ);
    assign next_acc = acc + STEP;
    assign tick     = (state == XFER_SHIFT) && (next_acc >= thresh);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || state != XFER_SHIFT) begin
            acc <= '0;
        end else if (tick) begin
            acc <= (next_acc - thresh >= thresh) ? '0 : next_acc - thresh;
        end else begin
            acc <= next_acc;
        end
    end

    assign change_edge = half_cnt[0] ^ spi_config_reg.clock_phase;
    assign byte_done   = tick && (half_cnt == `LAST_HALF_EDGE);
    assign next_rx_sr  = (tick && !change_edge)
                       ? (spi_config_reg.bit_order ? {miso, rx_sr[7:1]}
                                                   : {rx_sr[6:0], miso})
                       : rx_sr;
    assign tx_pop  = byte_done && from_fifo;
    assign rx_push = byte_done;
    assign mosi    = spi_config_reg.bit_order ? tx_sr[0] : tx_sr[7];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state     <= XFER_IDLE;
            half_cnt  <= '0;
            from_fifo <= 1'b0;
        end else if (start) begin
            state     <= XFER_SHIFT;
            half_cnt  <= '0;
            from_fifo <= tx_has && !pending_fe;
        end else if (byte_done) begin
            state     <= XFER_IDLE;
            from_fifo <= 1'b0;
        end else if (tick) begin
            half_cnt <= half_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_sr   <= '0;
            rx_sr   <= '0;
            last_tx <= '0;
        end else begin
            rx_sr <= next_rx_sr;
            if (start) begin
                tx_sr   <= load_byte;
                last_tx <= load_byte;
            end else if (tick && change_edge && !(spi_config_reg.clock_phase && half_cnt == '0)) begin
                tx_sr <= spi_config_reg.bit_order ? {1'b0, tx_sr[7:1]} : {tx_sr[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || state != XFER_SHIFT) begin
            master_serial_clock <= spi_config_reg.clock_polarity;
        end else if (tick) begin
            master_serial_clock <= !master_serial_clock;
        end
    end

    // polarity fall while in spi mode leaves a stray byte until mode reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pol_d      <= 1'b0;
            pending_fe <= 1'b0;
        end else begin
            pol_d <= spi_config_reg.clock_polarity;
            if (spi_config_reg.controller_mode_select == `MODE_OFF) begin
                pending_fe <= 1'b0;
            end else if (pol_d && !spi_config_reg.clock_polarity) begin
                pending_fe <= 1'b1;
            end else if (start) begin
                pending_fe <= 1'b0;
            end
        end
    end

    // status flags
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            spi_status_reg <= '{tx_idle_flag: 1'b1, tx_free_flag: 1'b1, default: 1'b0};
        end else begin
            spi_status_reg.tx_idle_flag  <= !tx_has && (state == XFER_IDLE);
            spi_status_reg.tx_free_flag  <= tx_ready;
            spi_status_reg.rx_valid_flag <= rx_valid;
            if (rx_push && !rx_in_ready) begin
                spi_status_reg.rx_overrun_flag <= 1'b1;
            end else if (rx_overrun_clear) begin
                spi_status_reg.rx_overrun_flag <= 1'b0;
            end
        end
    end

    // dma receive error waits for the fifo to drain
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_err_pending <= 1'b0;
            rx_dma_error   <= 1'b0;
            rx_unloaded    <= 1'b0;
        end else begin
            if (rx_push && !rx_in_ready) begin
                rx_err_pending <= 1'b1;
            end else if (rx_err_pending && !rx_valid) begin
                rx_err_pending <= 1'b0;
            end
            if (|(rx_act_d & ~rx_dma_buffer_active)) begin
                rx_unloaded <= 1'b1;
            end else if (rx_dma_load) begin
                rx_unloaded <= 1'b0;
            end
            if (rx_err_pending && !rx_valid) begin
                rx_dma_error <= 1'b1;
            end else if (dma_channel_reset[1] || (rx_dma_load && rx_unloaded)) begin
                rx_dma_error <= 1'b0;
            end
        end
    end

    // interrupt events
    always_comb begin
        events                = '0;
        events[`IRQ_RXVAL]    = spi_status_reg.rx_valid_flag && !status_d.rx_valid_flag;
        events[`IRQ_TXFREE]   = spi_status_reg.tx_free_flag && !status_d.tx_free_flag;
        events[`IRQ_TXIDLE]   = spi_status_reg.tx_idle_flag && !status_d.tx_idle_flag;
        events[`IRQ_RXOVF]    = rx_push && !rx_in_ready;
        events[`IRQ_TXUND]    = start_auto;
        events[`IRQ_RXULDA]   = rx_act_d[0] && !rx_dma_buffer_active[0];
        events[`IRQ_RXULDB]   = rx_act_d[1] && !rx_dma_buffer_active[1];
        events[`IRQ_TXULDA]   = tx_act_d[0] && !tx_dma_buffer_active[0];
        events[`IRQ_TXULDB]   = tx_act_d[1] && !tx_dma_buffer_active[1];
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_d     <= '{tx_idle_flag: 1'b1, tx_free_flag: 1'b1, default: 1'b0};
            tx_act_d     <= '0;
            rx_act_d     <= '0;
            irq_flag_reg <= '0;
        end else begin
            status_d     <= spi_status_reg;
            tx_act_d     <= tx_dma_buffer_active;
            rx_act_d     <= rx_dma_buffer_active;
            irq_flag_reg <= (irq_flag_reg & ~irq_flag_clear) | events;
        end
    end

    assign irq = irq_global_enable && |(irq_flag_reg & irq_enable_reg);

    property p_start_needs_master;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == XFER_IDLE) ##1 (state == XFER_SHIFT) |-> $past(active);
    endproperty
    a_start_needs_master: assert property (p_start_needs_master)
        else $error("byte started without master spi mode");
    property p_tick_rate;
        @(posedge sys_clk) disable iff (sys_rst)
        tick |-> (acc + STEP >= thresh);
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("divider ticked early");
    property p_first_bit;
        @(posedge sys_clk) disable iff (sys_rst)
        start |=> (mosi == (spi_config_reg.bit_order ? last_tx[0] : last_tx[7]));
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first bit not per bit order");
    property p_idle_flag;
        @(posedge sys_clk) disable iff (sys_rst)
        (!tx_has && state == XFER_IDLE) ##1 (!tx_has && state == XFER_IDLE)
            |-> spi_status_reg.tx_idle_flag;
    endproperty
    a_idle_flag: assert property (p_idle_flag)
        else $error("idle flag not set when drained");
    property p_free_flag;
        @(posedge sys_clk) disable iff (sys_rst)
        !tx_ready |=> !spi_status_reg.tx_free_flag;
    endproperty
    a_free_flag: assert property (p_free_flag)
        else $error("free flag set with full fifo");
    property p_overrun;
        @(posedge sys_clk) disable iff (sys_rst)
        (rx_push && !rx_in_ready) |=> spi_status_reg.rx_overrun_flag && irq_flag_reg[`IRQ_RXOVF];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");
    property p_underrun;
        @(posedge sys_clk) disable iff (sys_rst)
        start_auto |=> irq_flag_reg[`IRQ_TXUND];
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("automatic byte without underrun flag");
    property p_rx_pairs_tx;
        @(posedge sys_clk) disable iff (sys_rst)
        rx_push |-> (state == XFER_SHIFT) && (half_cnt == `LAST_HALF_EDGE);
    endproperty
    a_rx_pairs_tx: assert property (p_rx_pairs_tx)
        else $error("receive without a full transmit byte");
    property p_no_auto_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        (state == XFER_IDLE && !tx_has && !pending_fe && !spi_config_reg.auto_tx_enable)
            |=> (state == XFER_IDLE);
    endproperty
    a_no_auto_stop: assert property (p_no_auto_stop)
        else $error("transfer started with nothing to send");
    property p_dma_err_drained;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(rx_dma_error) |-> !$past(rx_valid);
    endproperty
    a_dma_err_drained: assert property (p_dma_err_drained)
        else $error("dma error before fifo drained");
endmodule : spi_master_with_fifos

// file: spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
    input  wire logic       master_serial_clock,
    input  wire logic       mosi,
    input  wire logic       clock_polarity,
    input  wire logic       clock_phase,
    input  wire logic [7:0] resp,
    output logic            miso,
    output logic [7:0]      got,
    output int              n_got
);
    logic [7:0] sr  = 8'h00;
    int         idx = 0;
    initial begin
        miso  = 1'b0;
        got   = 8'h00;
        n_got = 0;
    end
    // always listening: the master has no select pin
    always @(master_serial_clock) begin
        if ((master_serial_clock != clock_polarity) != clock_phase) begin
            sr  = {sr[6:0], mosi};
            idx = idx + 1;
            if (idx == 8) begin
                got   = sr;
                n_got = n_got + 1;
                idx   = 0;
            end
        end
    end
    // next bit settles after the sampling edge
    always @(idx, resp) miso <= #20 resp[7 - idx];
endmodule : spi_slave_model

// file: tb.sv
`timescale 1ns/1ps
`include "spi_master_cfg.svh"
module tb;
    import spi_pkg::*;
    logic        sys_clk = 1'b0, sys_rst = 1'b1;
    spi_cfg_s    cfg;
    spi_status_s st;
    logic        tx_valid = 1'b0, tx_ready, rx_valid, rx_ready = 1'b0, sclk, mosi, miso;
    logic        dma_err, irq, ovf_clr = 1'b0, gie = 1'b0, dma_load = 1'b0;
    logic [7:0]  tx_data = 8'h00, rx_data, got, resp, b;
    logic [1:0]  dma_rst = 2'h0, rx_act = 2'h0;
    logic [15:0] flags, fclr = 16'h0000, ien = 16'h0000;
    int          n_got, error_cnt = 0, comparisons = 0, n0, n1, k;
    always #50 sys_clk = ~sys_clk;
    assign resp = 8'h40 + n_got[7:0];
    spi_master_with_fifos i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_config_reg(cfg), .spi_status_reg(st),
        .rx_overrun_clear(ovf_clr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .master_serial_clock(sclk), .mosi(mosi), .miso(miso),
        .tx_dma_buffer_active(rx_act), .rx_dma_buffer_active(rx_act), .rx_dma_load(dma_load), .dma_channel_reset(dma_rst),
        .rx_dma_error(dma_err), .irq_flag_reg(flags), .irq_flag_clear(fclr), .irq_enable_reg(ien),
        .irq_global_enable(gie), .irq(irq));
    spi_slave_model i_slave (.master_serial_clock(sclk), .mosi(mosi), .clock_polarity(cfg.clock_polarity),
        .clock_phase(cfg.clock_phase), .resp(resp), .miso(miso), .got(got), .n_got(n_got));
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction : rev
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic hang;
        error_cnt++;
        stop_test();
    endtask : hang
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // holds valid up; caller drops it
    task automatic put(input logic [7:0] v);
        tx_valid <= 1'b1;
        tx_data  <= v;
        k = 0;
        do @(posedge sys_clk); while (tx_ready !== 1'b1 && ++k < 500);
        if (k >= 500) hang();
    endtask : put
    task automatic wait_n(input int t);
        for (k = 0; n_got < t; k++) begin
            if (k == 3000) hang();
            tick(1);
        end
        tick(3);
    endtask : wait_n
    task automatic get(input logic [7:0] e);
        chk("rx head", {7'h00, rx_valid, rx_data}, {8'h01, e});
        rx_ready <= 1'b1;
        tick(1);
        rx_ready <= 1'b0;
        tick(1);
    endtask : get
    task automatic drain;
        rx_ready <= 1'b1;
        tick(6);
        rx_ready <= 1'b0;
        tick(1);
    endtask : drain
    // polarity moves with phase 0 so the idle clock shift is no edge for the slave
    task automatic setm(input logic [2:0] m);
        cfg.controller_mode_select <= `MODE_OFF;
        cfg.clock_polarity         <= m[0];
        cfg.clock_phase            <= 1'b0;
        cfg.bit_order              <= m[2];
        tick(4);
        cfg.clock_phase            <= m[1];
        cfg.controller_mode_select <= `MODE_SPI;
        tick(2);
    endtask : setm
    initial begin
        cfg = '0;
        cfg.master_select_bit = 1'b1;
        cfg.pin_config = `PINS_THREE_MST;
        tick(10);
        sys_rst <= 1'b0;
        tick(1);
        chk("status", 16'(st), 16'h000c);
        chk("flags", flags, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            setm(3'(m));
            chk("sclk idle", 16'(sclk), 16'(m & 1));
            n0 = n_got;
            b = 8'h1d + 8'(m * 37);
            put(b);
            tx_valid <= 1'b0;
            wait_n(n0 + 1);
            chk("mosi byte", 16'(got), 16'(m > 3 ? rev(b) : b));
            get(m > 3 ? rev(8'h40 + 8'(n0)) : 8'h40 + 8'(n0));
        end
        ien <= 16'h0004;
        gie <= 1'b1;
        tick(1);
        chk("irq on", 16'({flags[`IRQ_TXIDLE], irq}), 16'h0003);
        gie <= 1'b0;
        fclr <= 16'hffff;
        tick(1);
        fclr <= 16'h0000;
        chk("irq off", {flags[14:0], irq}, 16'h0000);
        rx_act <= 2'h3;
        tick(2);
        rx_act <= 2'h0;
        tick(3);
        chk("dma done", flags & 16'h1e00, 16'h1e00);
        setm(3'h0);
        n0 = n_got;
        for (int i = 0; i < 4; i++) put(8'h10 + 8'(i));
        tx_valid <= 1'b0;
        tick(2);
        chk("full", {13'h0, tx_ready, st.tx_free_flag, st.tx_idle_flag}, 16'h0000);
        put(8'h14);
        tx_valid <= 1'b0;
        wait_n(n0 + 5);
        chk("overrun", 16'({st, flags[`IRQ_RXOVF], dma_err}), 16'h003e);
        chk("irq set", flags & 16'h001f, 16'h000f);
        for (int i = 0; i < 4; i++) get(8'h40 + 8'(n0 + i));
        tick(2);
        chk("dma err", 16'(dma_err), 16'h0001);
        dma_rst <= 2'h2;
        ovf_clr <= 1'b1;
        tick(1);
        dma_rst <= 2'h0;
        ovf_clr <= 1'b0;
        tick(2);
        chk("err clr", 16'({dma_err, st.rx_overrun_flag}), 16'h0000);
        n0 = n_got;
        for (int i = 0; i < 5; i++) put(8'h20 + 8'(i));
        tx_valid <= 1'b0;
        wait_n(n0 + 5);
        drain();
        chk("err again", 16'(dma_err), 16'h0001);
        dma_load <= 1'b1;
        tick(1);
        dma_load <= 1'b0;
        tick(1);
        chk("load clr", 16'(dma_err), 16'h0000);
        for (int r = 0; r < 2; r++) begin
            n0 = n_got;
            put(8'h77);
            tx_valid <= 1'b0;
            wait_n(n0 + 1);
            drain();
            cfg.repeat_select_bit <= r[0];
            cfg.auto_tx_enable    <= 1'b1;
            wait_n(n0 + 3);
            chk("filler", 16'(got), r ? 16'h0077 : 16'h00ff);
            chk("underrun", 16'(flags[`IRQ_TXUND]), 16'h0001);
            n1 = n_got;
            for (k = 0; n_got == n1; k++) begin
                if (k == 50) hang();
                tick(1);
            end
            tick(1);
            cfg.auto_tx_enable <= 1'b0; // fifo empty and shifter idle
            tick(40);
            n1 = n_got;
            tick(100);
            chk("rx stops", {n_got[7:0] - n1[7:0], 7'h00, rx_valid}, 16'h0001);
            drain();
        end
        n0 = n_got;
        put(8'h99);
        tx_valid <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            cfg.pin_config <= i == 0 ? `PINS_FOUR_SLV : (i == 1 ? `PINS_TWO_WIRE : `PINS_THREE_MST);
            cfg.master_select_bit <= i != 2;
            cfg.controller_mode_select <= i == 3 ? `MODE_OFF : `MODE_SPI;
            tick(60);
            chk("no shift", 16'(n_got - n0), 16'h0000);
        end
        cfg.controller_mode_select <= `MODE_SPI;
        wait_n(n0 + 1);
        chk("held byte", 16'(got), 16'h0099);
        drain();
        setm(3'h1);
        n0 = n_got;
        put(8'h31);
        tx_valid <= 1'b0;
        wait_n(n0 + 1);
        cfg.clock_polarity <= 1'b0;
        tick(4);
        put(8'h32);
        tx_valid <= 1'b0;
        wait_n(n0 + 2);
        chk("glitch", 16'(got), 16'h00fe);
        wait_n(n0 + 3);
        chk("after", 16'(got), 16'h0032);
        drain();
        setm(3'h0);
        cfg.rate_linear   <= 4'h5;
        cfg.rate_exponent <= 4'h1;
        n0 = n_got;
        put(8'h55);
        tx_valid <= 1'b0;
        for (k = 0; n_got == n0 && k < 300; k++) tick(1);
        chk("byte time", 16'(k >= 76 && k <= 86), 16'h0001);
        stop_test();
    end
endmodule : tb
